// >>> rtl/gp_params.svh
// Purpose: Named constants of the pin mode and lock block
// Assumes: Byte addresses on a 32-bit register bus
// Notes:   Definitions only
`ifndef GP_PARAMS_SVH
`define GP_PARAMS_SVH

`define GP_NUM_PINS        16
`define GP_PINS_PER_REG    8
`define GP_MODE_W          4
`define GP_ADDR_W          12

`define GP_OFF_CTRL        12'h000
`define GP_OFF_MODE_LOW    12'h004
`define GP_OFF_MODE_HIGH   12'h008
`define GP_OFF_DOUT        12'h00C
`define GP_OFF_PIN_IN      12'h010
`define GP_OFF_PIN_LOCK    12'h014
`define GP_OFF_IRQ_SEL_LOW 12'h100
`define GP_OFF_IRQ_SEL_HI  12'h104
`define GP_OFF_DBG_ROUTE   12'h120
`define GP_OFF_IN_SENSE    12'h124
`define GP_OFF_LOCK        12'h128

`define GP_RST_CTRL        2'h0
`define GP_RST_MODE        32'h00000000
`define GP_RST_DOUT        16'h0000
`define GP_RST_PIN_LOCK    16'hFFFF
`define GP_RST_IRQ_SEL     32'h00000000
`define GP_RST_DBG_ROUTE   2'h3
`define GP_RST_IN_SENSE    2'h3
`define GP_RST_LOCK_KEY    16'h0000

`define GP_UNLOCK_CODE     16'hA534
`define GP_CTRL_W          2
`define GP_INS_INT_BIT     0
`define GP_INS_RFX_BIT     1
`define GP_DBG_CLK_BIT     0
`define GP_DBG_DATA_BIT    1

`define GP_MODE_DISABLED   4'h0
`define GP_MODE_IN_PF      4'h3
`define GP_MODE_PP         4'h4
`define GP_MODE_PP_ALT     4'h5
`define GP_MODE_OS         4'h6
`define GP_MODE_OS_PD      4'h7
`define GP_OD_FILT_BIT     0
`define GP_OD_PU_BIT       1
`define GP_OD_ALT_BIT      2
`define GP_OD_FLAG_BIT     3

`define GP_RESP_OKAY       2'h0
`define GP_RESP_SLVERR     2'h2

`endif

// >>> rtl/gp_pkg.sv
// Purpose: Types shared by the pin mode and lock block
// Assumes: Nothing beyond the constants header
// Notes:   One pad control word per pin
package gp_pkg;

    typedef struct packed {
        logic in_en;
        logic drv_oe;
        logic drv_out;
        logic pull_up;
        logic pull_dn;
        logic filt_en;
        logic alt_drv;
    } gp_pad_t;

    typedef enum logic [1:0] {
        GP_RD_IDLE,
        GP_RD_RESP
    } gp_rd_state_t;

endpackage

// >>> rtl/gp_pin_sync.sv
// Purpose: Two-stage synchroniser for pad inputs
// Assumes: Pins change with no relation to aclk
// Notes:   First stage is read by the second only
`timescale 1ns/1ns
module gp_pin_sync #(
    parameter int WIDTH = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_in;
            sync_ff <= meta_ff;
        end
    end

    assign sync_out = sync_ff;

endmodule

// >>> rtl/gp_port_cfg.sv
// Purpose: Pin mode decode, pad control and config lock of a GPIO port
// Assumes: AXI4-Lite register access, one clock, synchronous low reset
// Notes:   Pad controls are registered, one cycle behind the mode registers
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ns
`include "gp_params.svh"
module gp_port_cfg
    import gp_pkg::*;
(
    input  wire logic                            aclk,
    input  wire logic                            aresetn,
    input  wire logic [`GP_ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic                            s_axi_awvalid,
    output logic                                 s_axi_awready,
    input  wire logic [31:0]                     s_axi_wdata,
    input  wire logic [3:0]                      s_axi_wstrb,
    input  wire logic                            s_axi_wvalid,
    output logic                                 s_axi_wready,
    output logic [1:0]                           s_axi_bresp,
    output logic                                 s_axi_bvalid,
    input  wire logic                            s_axi_bready,
    input  wire logic [`GP_ADDR_W-1:0]           s_axi_araddr,
    input  wire logic                            s_axi_arvalid,
    output logic                                 s_axi_arready,
    output logic [31:0]                          s_axi_rdata,
    output logic [1:0]                           s_axi_rresp,
    output logic                                 s_axi_rvalid,
    input  wire logic                            s_axi_rready,
    input  wire logic [`GP_NUM_PINS-1:0]         pin_in,
    output gp_pad_t [`GP_NUM_PINS-1:0]           pad_ctrl,
    output logic [`GP_CTRL_W-1:0]                alt_strength_sel,
    output logic [`GP_NUM_PINS-1:0]              irq_sense,
    output logic [`GP_NUM_PINS-1:0]              reflex_sense,
    output logic                                 debug_clk_pin_en,
    output logic                                 debug_data_pin_en
);

    localparam int NP = `GP_NUM_PINS;
    localparam int MW = `GP_MODE_W;
    localparam int PR = `GP_PINS_PER_REG;

    // Bus side state
    logic                     aw_got_ff;
    logic                     w_got_ff;
    logic [`GP_ADDR_W-1:0]    aw_addr_ff;
    logic [31:0]              wdata_ff;
    logic [3:0]               wstrb_ff;
    logic                     awready_ff;
    logic                     wready_ff;
    logic                     bvalid_ff;
    logic [1:0]               bresp_ff;
    gp_rd_state_t             rd_state_ff;
    logic                     arready_ff;
    logic                     rvalid_ff;
    logic [31:0]              rdata_ff;
    logic [1:0]               rresp_ff;
    logic                     nxt_aw_got;
    logic                     nxt_w_got;
    logic                     nxt_bvalid;
    logic                     do_wr;

    // Configuration state
    logic [`GP_CTRL_W-1:0]    ctrl_ff;
    logic [NP*MW-1:0]         mode_ff;
    logic [NP-1:0]            dout_ff;
    logic [NP-1:0]            pin_lock_ff;
    logic [31:0]              irq_sel_low_ff;
    logic [31:0]              irq_sel_high_ff;
    logic [1:0]               dbg_route_ff;
    logic [1:0]               in_sense_ff;
    logic                     locked_ff;

    // Pad side
    logic [NP-1:0]            pin_sync;
    gp_pad_t [NP-1:0]         pad_ff;
    logic [NP-1:0]            irq_sense_ff;
    logic [NP-1:0]            reflex_sense_ff;
    logic [NP-1:0]            in_en_vec;
    logic [31:0]              wr_merged;

    gp_pin_sync #(
        .WIDTH    (NP)
    ) u_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    function automatic logic [31:0] strb_merge(input logic [31:0] old_val,
                                               input logic [31:0] new_val,
                                               input logic [3:0]  strb);
        logic [31:0] res;
        res = old_val;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_val[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // Pins whose lock-mask bit is clear keep their mode field
    function automatic logic [31:0] pin_guard(input logic [31:0]   old_val,
                                              input logic [31:0]   new_val,
                                              input logic [PR-1:0] allow);
        logic [31:0] res;
        res = old_val;
        for (int p = 0; p < PR; p++) begin
            if (allow[p]) begin
                res[p*MW +: MW] = new_val[p*MW +: MW];
            end
        end
        return res;
    endfunction

    function automatic logic addr_ok(input logic [`GP_ADDR_W-1:0] a);
        return (a == `GP_OFF_CTRL) || (a == `GP_OFF_MODE_LOW) || (a == `GP_OFF_MODE_HIGH)
            || (a == `GP_OFF_DOUT) || (a == `GP_OFF_PIN_IN) || (a == `GP_OFF_PIN_LOCK)
            || (a == `GP_OFF_IRQ_SEL_LOW) || (a == `GP_OFF_IRQ_SEL_HI)
            || (a == `GP_OFF_DBG_ROUTE) || (a == `GP_OFF_IN_SENSE) || (a == `GP_OFF_LOCK);
    endfunction

    // Current register contents, shared by reads and the write merge
    function automatic logic [31:0] reg_value(input logic [`GP_ADDR_W-1:0] a);
        logic [31:0] v;
        v = '0;
        if (a == `GP_OFF_CTRL) begin
            v[`GP_CTRL_W-1:0] = ctrl_ff;
        end else if (a == `GP_OFF_MODE_LOW) begin
            v = mode_ff[31:0];
        end else if (a == `GP_OFF_MODE_HIGH) begin
            v = mode_ff[63:32];
        end else if (a == `GP_OFF_DOUT) begin
            v[NP-1:0] = dout_ff;
        end else if (a == `GP_OFF_PIN_IN) begin
            v[NP-1:0] = pin_sync;
        end else if (a == `GP_OFF_PIN_LOCK) begin
            v[NP-1:0] = pin_lock_ff;
        end else if (a == `GP_OFF_IRQ_SEL_LOW) begin
            v = irq_sel_low_ff;
        end else if (a == `GP_OFF_IRQ_SEL_HI) begin
            v = irq_sel_high_ff;
        end else if (a == `GP_OFF_DBG_ROUTE) begin
            v[1:0] = dbg_route_ff;
        end else if (a == `GP_OFF_IN_SENSE) begin
            v[1:0] = in_sense_ff;
        end else if (a == `GP_OFF_LOCK) begin
            v[0] = locked_ff;
        end
        return v;
    endfunction

    function automatic gp_pad_t decode_mode(input logic [MW-1:0] m, input logic d);
        gp_pad_t p;
        p = '0;
        p.in_en = (m != `GP_MODE_DISABLED);
        case (m)
            `GP_MODE_IN_PF: begin
                p.filt_en = 1'b1;
                p.pull_up = d;
                p.pull_dn = !d;
            end
            `GP_MODE_PP, `GP_MODE_PP_ALT: begin
                p.drv_oe  = 1'b1;
                p.drv_out = d;
                p.alt_drv = (m == `GP_MODE_PP_ALT);
            end
            `GP_MODE_OS, `GP_MODE_OS_PD: begin
                // Wired-OR: drive only the high level
                p.drv_oe  = d;
                p.drv_out = 1'b1;
                p.pull_dn = (m == `GP_MODE_OS_PD);
            end
            default: begin
                if (m[`GP_OD_FLAG_BIT]) begin
                    // Wired-AND: drive only the low level
                    p.drv_oe  = !d;
                    p.drv_out = 1'b0;
                    p.filt_en = m[`GP_OD_FILT_BIT];
                    p.pull_up = m[`GP_OD_PU_BIT];
                    p.alt_drv = m[`GP_OD_ALT_BIT];
                end
            end
        endcase
        return p;
    endfunction

    // Write channel acceptance, either order
    always_comb begin
        do_wr      = aw_got_ff && w_got_ff && !bvalid_ff;
        nxt_aw_got = aw_got_ff;
        nxt_w_got  = w_got_ff;
        nxt_bvalid = bvalid_ff;
        if (s_axi_awvalid && awready_ff) begin
            nxt_aw_got = 1'b1;
        end
        if (s_axi_wvalid && wready_ff) begin
            nxt_w_got = 1'b1;
        end
        if (do_wr) begin
            nxt_aw_got = 1'b0;
            nxt_w_got  = 1'b0;
            nxt_bvalid = 1'b1;
        end else if (bvalid_ff && s_axi_bready) begin
            nxt_bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_ff  <= 1'b0;
            w_got_ff   <= 1'b0;
            bvalid_ff  <= 1'b0;
            awready_ff <= 1'b0;
            wready_ff  <= 1'b0;
            bresp_ff   <= `GP_RESP_OKAY;
            aw_addr_ff <= '0;
            wdata_ff   <= '0;
            wstrb_ff   <= '0;
        end else begin
            aw_got_ff  <= nxt_aw_got;
            w_got_ff   <= nxt_w_got;
            bvalid_ff  <= nxt_bvalid;
            // No new write is taken until the response is gone
            awready_ff <= !nxt_aw_got && !nxt_bvalid;
            wready_ff  <= !nxt_w_got && !nxt_bvalid;
            if (s_axi_awvalid && awready_ff) begin
                aw_addr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && wready_ff) begin
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_wr) begin
                bresp_ff <= addr_ok(aw_addr_ff) ? `GP_RESP_OKAY : `GP_RESP_SLVERR;
            end
        end
    end

    assign wr_merged = strb_merge(reg_value(aw_addr_ff), wdata_ff, wstrb_ff);

    // Protected configuration
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_ff         <= `GP_RST_CTRL;
            mode_ff         <= {`GP_RST_MODE, `GP_RST_MODE};
            pin_lock_ff     <= `GP_RST_PIN_LOCK;
            irq_sel_low_ff  <= `GP_RST_IRQ_SEL;
            irq_sel_high_ff <= `GP_RST_IRQ_SEL;
            dbg_route_ff    <= `GP_RST_DBG_ROUTE;
            in_sense_ff     <= `GP_RST_IN_SENSE;
        end else if (do_wr && !locked_ff) begin
            if (aw_addr_ff == `GP_OFF_CTRL) begin
                ctrl_ff <= wr_merged[`GP_CTRL_W-1:0];
            end else if (aw_addr_ff == `GP_OFF_MODE_LOW) begin
                mode_ff[31:0] <= pin_guard(mode_ff[31:0], wr_merged, pin_lock_ff[PR-1:0]);
            end else if (aw_addr_ff == `GP_OFF_MODE_HIGH) begin
                mode_ff[63:32] <= pin_guard(mode_ff[63:32], wr_merged, pin_lock_ff[NP-1:PR]);
            end else if (aw_addr_ff == `GP_OFF_PIN_LOCK) begin
                // Mask bits only clear; reset is the way back
                pin_lock_ff <= pin_lock_ff & wr_merged[NP-1:0];
            end else if (aw_addr_ff == `GP_OFF_IRQ_SEL_LOW) begin
                irq_sel_low_ff <= wr_merged;
            end else if (aw_addr_ff == `GP_OFF_IRQ_SEL_HI) begin
                irq_sel_high_ff <= wr_merged;
            end else if (aw_addr_ff == `GP_OFF_DBG_ROUTE) begin
                dbg_route_ff <= wr_merged[1:0];
            end else if (aw_addr_ff == `GP_OFF_IN_SENSE) begin
                in_sense_ff <= wr_merged[1:0];
            end
        end
    end

    // Data-out stays writable under the lock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            dout_ff <= `GP_RST_DOUT;
        end else if (do_wr && aw_addr_ff == `GP_OFF_DOUT) begin
            dout_ff <= wr_merged[NP-1:0];
        end
    end

    // Lock key, never itself locked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            locked_ff   <= 1'b0;
        end else if (do_wr && aw_addr_ff == `GP_OFF_LOCK) begin
            locked_ff   <= (wr_merged[15:0] != `GP_UNLOCK_CODE);
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rd_state_ff <= GP_RD_IDLE;
            arready_ff  <= 1'b0;
            rvalid_ff   <= 1'b0;
            rdata_ff    <= '0;
            rresp_ff    <= `GP_RESP_OKAY;
        end else begin
            case (rd_state_ff)
                GP_RD_IDLE: begin
                    arready_ff <= 1'b1;
                    if (s_axi_arvalid && arready_ff) begin
                        rd_state_ff <= GP_RD_RESP;
                        arready_ff  <= 1'b0;
                        rvalid_ff   <= 1'b1;
                        rdata_ff    <= reg_value(s_axi_araddr);
                        rresp_ff    <= addr_ok(s_axi_araddr) ? `GP_RESP_OKAY
                                                             : `GP_RESP_SLVERR;
                    end
                end
                GP_RD_RESP: begin
                    if (s_axi_rready) begin
                        rd_state_ff <= GP_RD_IDLE;
                        rvalid_ff   <= 1'b0;
                        arready_ff  <= 1'b1;
                    end
                end
                default: begin
                    rd_state_ff <= GP_RD_IDLE;
                end
            endcase
        end
    end

    // Pad controls and sensing
    always_comb begin
        for (int i = 0; i < NP; i++) begin
            in_en_vec[i] = pad_ff[i].in_en;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_ff          <= '0;
            irq_sense_ff    <= '0;
            reflex_sense_ff <= '0;
        end else begin
            for (int i = 0; i < NP; i++) begin
                pad_ff[i] <= decode_mode(mode_ff[i*MW +: MW], dout_ff[i]);
            end
            // Disabled pins never reach the sense paths
            irq_sense_ff    <= pin_sync & in_en_vec & {NP{in_sense_ff[`GP_INS_INT_BIT]}};
            reflex_sense_ff <= pin_sync & in_en_vec & {NP{in_sense_ff[`GP_INS_RFX_BIT]}};
        end
    end

    assign s_axi_awready     = awready_ff;
    assign s_axi_wready      = wready_ff;
    assign s_axi_bvalid      = bvalid_ff;
    assign s_axi_bresp       = bresp_ff;
    assign s_axi_arready     = arready_ff;
    assign s_axi_rvalid      = rvalid_ff;
    assign s_axi_rdata       = rdata_ff;
    assign s_axi_rresp       = rresp_ff;
    assign pad_ctrl          = pad_ff;
    assign alt_strength_sel  = ctrl_ff;
    assign irq_sense         = irq_sense_ff;
    assign reflex_sense      = reflex_sense_ff;
    assign debug_clk_pin_en  = dbg_route_ff[`GP_DBG_CLK_BIT];
    assign debug_data_pin_en = dbg_route_ff[`GP_DBG_DATA_BIT];

endmodule

// >>> testbench/gp_port_cfg_monitor.sv
// Purpose: Port-level checks of the pin mode and lock block
// Assumes: Bound to gp_port_cfg, single clock, synchronous low reset
// Notes:   Pin 0 stands in for all pins to keep the checker small
`timescale 1ns/1ns
`include "gp_params.svh"
module gp_port_cfg_monitor
    import gp_pkg::*;
(
    input wire logic                         aclk,
    input wire logic                         aresetn,
    input wire logic                         s_axi_awvalid,
    input wire logic                         s_axi_awready,
    input wire logic                         s_axi_wvalid,
    input wire logic                         s_axi_wready,
    input wire logic [1:0]                   s_axi_bresp,
    input wire logic                         s_axi_bvalid,
    input wire logic [`GP_ADDR_W-1:0]        s_axi_araddr,
    input wire logic                         s_axi_arvalid,
    input wire logic                         s_axi_arready,
    input wire logic [31:0]                  s_axi_rdata,
    input wire logic                         s_axi_rvalid,
    input wire gp_pad_t [`GP_NUM_PINS-1:0]   pad_ctrl,
    input wire logic [`GP_NUM_PINS-1:0]      irq_sense,
    input wire logic [`GP_NUM_PINS-1:0]      reflex_sense,
    input wire logic                         debug_clk_pin_en,
    input wire logic                         debug_data_pin_en
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire gp_pad_t p0 = pad_ctrl[0];

    dis_pad_a: assert property (!p0.in_en |-> p0 == 7'h00)
        else $error("disabled pin still has pad controls");
    pull_excl_a: assert property (p0.in_en |-> !(p0.pull_up && p0.pull_dn))
        else $error("pull-up and pull-down both on");
    filt_in_a: assert property (p0.filt_en |-> p0.in_en)
        else $error("filter on a disabled pin");
    // Three cycles cover the synchroniser and the sense register
    irq_gate_a: assert property (!p0.in_en [*3] |=> !irq_sense[0])
        else $error("interrupt sense from disabled pin");
    rfx_gate_a: assert property (!p0.in_en [*3] |=> !reflex_sense[0])
        else $error("reflex sense from disabled pin");
    dbg_rst_a: assert property ($rose(aresetn) |-> debug_clk_pin_en && debug_data_pin_en)
        else $error("debug pins not connected after reset");
    wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> !s_axi_bvalid ##1 s_axi_bvalid)
        else $error("write response not on time");
    aw_busy_a: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
        else $error("write address taken twice");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    lock_rd_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `GP_OFF_LOCK
        |=> s_axi_rdata[31:1] == 31'h0)
        else $error("lock read shows more than bit 0");

    cover property (s_axi_bvalid && s_axi_bresp == `GP_RESP_SLVERR);
    cover property ($rose(irq_sense[0]));
    cover property (p0.alt_drv && p0.drv_oe);
endmodule

bind gp_port_cfg gp_port_cfg_monitor i_gp_port_cfg_monitor (.aclk, .aresetn, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .pad_ctrl, .irq_sense,
    .reflex_sense, .debug_clk_pin_en, .debug_data_pin_en);

// >>> testbench/gp_pin_pin_mode_low_reg.sv
// Purpose: Board side of the port pins
// Assumes: Board drives ext_level weakly; pad drivers and pulls win
// Notes:   No analog strengths, a pull simply beats the board
`timescale 1ns/1ns
`include "gp_params.svh"
module gp_pin_pin_mode_low_reg
    import gp_pkg::*;
(
    input wire gp_pad_t [`GP_NUM_PINS-1:0]   pad_ctrl,
    input wire logic [`GP_NUM_PINS-1:0]      ext_level,
    output logic [`GP_NUM_PINS-1:0]          pin_in
);
    always_comb begin
        for (int k = 0; k < `GP_NUM_PINS; k++) begin
            if (pad_ctrl[k].drv_oe)
                pin_in[k] = pad_ctrl[k].drv_out;
            else if (pad_ctrl[k].pull_up || pad_ctrl[k].pull_dn)
                pin_in[k] = pad_ctrl[k].pull_up;
            else
                pin_in[k] = ext_level[k];
        end
    end
endmodule

// >>> testbench/gp_pin_mode_and_lock_tb.sv
// Purpose: Self-checking bench of the pin mode and lock block
// Assumes: AXI4-Lite master tasks, board pin_mode_low_reg on the pins
// Notes:   Fixed seed, so every run repeats
`timescale 1ns/1ns
`include "gp_params.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_count++; \
    $display("mismatch at %0t: got %h expected %h", $time, (g), (e)); end end
module gp_pin_mode_and_lock_tb
    import gp_pkg::*;
;
    logic                aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic                s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
    logic                s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic                debug_clk_pin_en, debug_data_pin_en;
    logic [11:0]         s_axi_awaddr, s_axi_araddr;
    logic [31:0]         s_axi_wdata, s_axi_rdata, ml, mh, dv;
    logic [3:0]          s_axi_wstrb;
    logic [1:0]          s_axi_bresp, s_axi_rresp, alt_strength_sel;
    logic [15:0]         pin_in, irq_sense, reflex_sense, ext_level;
    gp_pad_t [15:0]      pad_ctrl;
    gp_pad_t             ep;
    logic [31:0]         v [8];
    logic [11:0]         a [8];
    int                  err_count, n_checks, i, j;
    integer              seed;

    gp_port_cfg i_gp_port_cfg (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .pin_in, .pad_ctrl, .alt_strength_sel,
        .irq_sense, .reflex_sense, .debug_clk_pin_en, .debug_data_pin_en);
    gp_pin_pin_mode_low_reg i_gp_pin_pin_mode_low_reg (.pad_ctrl, .ext_level, .pin_in);

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    function automatic gp_pad_t xp(input logic [3:0] m, input logic d);
        gp_pad_t p;
        p = '0;
        p.in_en = (m != 4'h0);
        case (m)
            4'h3: begin
                p.filt_en = 1'b1;
                p.pull_up = d;
                p.pull_dn = !d;
            end
            4'h4, 4'h5: begin
                p.drv_oe = 1'b1;
                p.drv_out = d;
                p.alt_drv = m[0];
            end
            4'h6, 4'h7: begin
                p.drv_oe = d;
                p.drv_out = 1'b1;
                p.pull_dn = m[0];
            end
            default: if (m[3]) begin
                p.drv_oe = !d;
                p.filt_en = m[0];
                p.pull_up = m[1];
                p.alt_drv = m[2];
            end
        endcase
        return p;
    endfunction

    function automatic logic lv(input gp_pad_t p, input logic e);
        if (p.drv_oe) return p.drv_out;
        if (p.pull_up || p.pull_dn) return p.pull_up;
        return e;
    endfunction

    task automatic give_verdict;
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask

    task automatic tmo(input int k);
        if (k >= 64) begin
            err_count++;
            $display("mismatch at %0t: bus wait ran out", $time);
            give_verdict;
        end
    endtask

    task automatic wr(input logic [11:0] ad, input logic [31:0] d,
                      input logic [1:0] er = `GP_RESP_OKAY);
        int k;
        logic aw, w;
        @(posedge aclk);
        aw = 1'b0;
        w = 1'b0;
        s_axi_awaddr <= ad;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (k = 0; k < 64 && !(aw && w); k++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                aw = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
        end
        tmo(k);
        for (k = 0; k < 64 && !s_axi_bvalid; k++) @(posedge aclk);
        tmo(k);
        `CHK(s_axi_bresp, er)
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                      input logic [1:0] er = `GP_RESP_OKAY);
        int k;
        @(posedge aclk);
        s_axi_araddr <= ad;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (k = 0; k < 64 && !s_axi_rvalid; k++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
        end
        tmo(k);
        `CHK(s_axi_rdata, e)
        `CHK(s_axi_rresp, er)
        s_axi_rready <= 1'b0;
    endtask

    task automatic do_reset;
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
    endtask

    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb, ext_level} = '0;
        seed = 32'h02919469;
        err_count = 0;
        n_checks = 0;
        do_reset;
        rd(`GP_OFF_IN_SENSE, 32'h3);
        rd(`GP_OFF_LOCK, 32'h0);
        rd(`GP_OFF_DBG_ROUTE, 32'h3);
        for (i = 0; i < 16; i++) begin
            ml = $random(seed);
            mh = $random(seed);
            dv = {16'h0, 16'($random(seed))};
            ml[3:0] = i[3:0];
            ext_level <= 16'($random(seed));
            wr(`GP_OFF_DOUT, dv);
            wr(`GP_OFF_MODE_LOW, ml);
            wr(`GP_OFF_MODE_HIGH, mh);
            wr(`GP_OFF_IN_SENSE, {30'h0, i[1:0]});
            repeat (6) @(posedge aclk);
            for (j = 0; j < 16; j++) begin
                ep = xp(j < 8 ? ml[4*j+:4] : mh[4*j-32+:4], dv[j]);
                `CHK(pad_ctrl[j], ep)
                `CHK(irq_sense[j], lv(ep, ext_level[j]) & ep.in_en & i[0])
                `CHK(reflex_sense[j], lv(ep, ext_level[j]) & ep.in_en & i[1])
            end
        end
        a = '{`GP_OFF_CTRL, `GP_OFF_MODE_LOW, `GP_OFF_MODE_HIGH, `GP_OFF_PIN_LOCK,
              `GP_OFF_IRQ_SEL_LOW, `GP_OFF_IRQ_SEL_HI, `GP_OFF_IN_SENSE, `GP_OFF_DBG_ROUTE};
        v = '{32'h2, ml, mh, 32'hFFFF, $random(seed), $random(seed), 32'h3, 32'h3};
        for (i = 0; i < 8; i++) wr(a[i], v[i]);
        wr(`GP_OFF_LOCK, 32'h1234);
        rd(`GP_OFF_LOCK, 32'h1);
        for (i = 0; i < 8; i++) begin
            wr(a[i], ~v[i]);
            rd(a[i], v[i]);
        end
        `CHK(debug_clk_pin_en, 1'b1)
        `CHK(alt_strength_sel, 2'h2)
        wr(`GP_OFF_LOCK, 32'h0);
        rd(`GP_OFF_LOCK, 32'h1);
        wr(`GP_OFF_LOCK, 32'hA534);
        rd(`GP_OFF_LOCK, 32'h0);
        wr(`GP_OFF_MODE_LOW, 32'h5);
        rd(`GP_OFF_MODE_LOW, 32'h5);
        wr(12'h200, 32'hFFFF, `GP_RESP_SLVERR);
        rd(12'h200, 32'h0, `GP_RESP_SLVERR);
        // Start-up delay before this is software's duty, skipped in simulation
        wr(`GP_OFF_DBG_ROUTE, 32'h0);
        repeat (3) @(posedge aclk);
        `CHK({debug_data_pin_en, debug_clk_pin_en}, 2'h0)
        do_reset;
        @(posedge aclk);
        `CHK({debug_data_pin_en, debug_clk_pin_en}, 2'h3)
        rd(`GP_OFF_DBG_ROUTE, 32'h3);
        give_verdict;
    end
endmodule
